// ### bmt_timing.sv
`timescale 1ns/1ps
module bmt_timing (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire bmt_pkg::bmt_cfg_t i_cfg,
	input wire logic i_bc_start,
	input wire logic i_msg_done,
	input wire logic i_more_msgs,
	input wire logic i_xfer_start_seq,
	input wire logic i_xfer_end_seq,
	input wire logic i_host_access,
	input wire logic i_resp_arm,
	input wire logic i_resp_sync,
	input wire logic i_rt_cmd_parity,
	output logic o_msg_go,
	output logic o_no_resp,
	output logic o_rt_reply_go
);
	typedef enum logic [1:0] {BMT_IDLE, BMT_START, BMT_BUSY, BMT_GAP} bmt_state_t;

	// Step a down-counter, holding at zero
	function automatic logic [15:0] bmt_dec16(input logic [15:0] val);
		if (val == 16'h0000)
			bmt_dec16 = 16'h0000;
		else
			bmt_dec16 = val - 16'h0001;
	endfunction

	// Message sequencing
	bmt_state_t state_q;
	bmt_state_t state_d;
	logic go_d;

	// Gap timing
	logic [15:0] cnt_q;
	logic [15:0] gap_load;
	logic gap_done;
	logic [15:0] steps_q;
	logic [7:0] tick_q;
	logic tick;

	// Host extension
	logic [6:0] ext_add;
	logic [6:0] ext_q;
	logic [6:0] ext_used_q;
	logic ext_done;
	logic [3:0] xfers_q;

	// Response timers
	logic [15:0] to_q;
	logic to_run_q;
	logic [9:0] rt_q;
	logic rt_run_q;

	// Microsecond tick, restarted at each gap entry
	assign tick = (tick_q == 8'(bmt_pkg::STEP_CYC - 1));

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || state_q != BMT_GAP || tick)
			tick_q <= 8'h00;
		else
			tick_q <= tick_q + 8'h01;
	end

	// Host stall accounting, capped by transfer count
	always_comb begin
		ext_add = 7'h00;
		if (i_cfg.host_prio && i_host_access && (i_xfer_start_seq || i_xfer_end_seq) &&
			xfers_q < 4'(bmt_pkg::START_XFERS + bmt_pkg::END_XFERS))
			ext_add = 7'(bmt_pkg::HOST_EXT_CYC);
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || o_msg_go) begin
			ext_q <= 7'h00;
			xfers_q <= 4'h0;
		end else if (ext_add != 7'h00) begin
			ext_q <= ext_q + ext_add;
			xfers_q <= xfers_q + 4'h1;
		end
	end

	// Host extension drains after the fixed gap
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || state_q != BMT_GAP)
			ext_used_q <= 7'h00;
		else if (cnt_q == 16'h0000 && !ext_done)
			ext_used_q <= ext_used_q + 7'h01;
	end

	assign ext_done = (ext_used_q >= ext_q);

	// Fixed gap length, longer in sequencer mode
	always_comb begin
		gap_load = 16'(bmt_pkg::GAP_MIN_CYC - 1);
		if (i_cfg.seq_mode)
			gap_load = gap_load + 16'(bmt_pkg::SEQ_EXTRA_CYC);
	end

	assign gap_done = (cnt_q == 16'h0000) && (steps_q == 16'h0000) && ext_done;

	// Next state and message launch
	always_comb begin
		state_d = state_q;
		go_d = 1'b0;
		unique case (state_q)
			BMT_IDLE: begin
				if (i_bc_start)
					state_d = BMT_START;
			end
			BMT_START: begin
				if (cnt_q == 16'h0000) begin
					state_d = BMT_BUSY;
					go_d = 1'b1;
				end
			end
			BMT_BUSY: begin
				if (i_msg_done && i_more_msgs)
					state_d = BMT_GAP;
				else if (i_msg_done)
					state_d = BMT_IDLE;
			end
			BMT_GAP: begin
				if (gap_done) begin
					state_d = BMT_BUSY;
					go_d = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			state_q <= BMT_IDLE;
		else
			state_q <= state_d;
	end

	// Registered one-cycle launch pulse
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			o_msg_go <= 1'b0;
		else
			o_msg_go <= go_d;
	end

	// Fixed part of the start delay and of the gap
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			cnt_q <= 16'h0000;
		else if (state_q == BMT_IDLE && i_bc_start)
			cnt_q <= 16'(bmt_pkg::START_DLY_CYC - 1);
		else if (state_q == BMT_BUSY && i_msg_done)
			cnt_q <= gap_load;
		else if (state_q == BMT_START || state_q == BMT_GAP)
			cnt_q <= bmt_dec16(cnt_q);
	end

	// Programmed gap length, one step per tick, counted alongside the fixed part
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			steps_q <= bmt_pkg::GAP_RESET;
		else if (state_q == BMT_BUSY && i_msg_done)
			steps_q <= i_cfg.gap_steps;
		else if (state_q == BMT_GAP && tick)
			steps_q <= bmt_dec16(steps_q);
	end

	// No-response timeout, also for terminal-to-terminal transfers
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			to_run_q <= 1'b0;
			to_q <= 16'h0000;
		end else if (i_resp_arm) begin
			to_run_q <= 1'b1;
			to_q <= bmt_pkg::bmt_timeout_cyc(i_cfg.timeout_sel);
		end else if (to_run_q) begin
			if (i_resp_sync || to_q == 16'h0000)
				to_run_q <= 1'b0;
			to_q <= bmt_dec16(to_q);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			o_no_resp <= 1'b0;
		else
			o_no_resp <= !i_resp_arm && to_run_q && !i_resp_sync && to_q == 16'h0000;
	end

	// Remote terminal reply launch at the start of the window
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			rt_run_q <= 1'b0;
			rt_q <= 10'h000;
		end else if (i_rt_cmd_parity) begin
			rt_run_q <= 1'b1;
			rt_q <= 10'h000;
		end else if (rt_run_q) begin
			rt_q <= rt_q + 10'h001;
			if (rt_q == 10'(bmt_pkg::RESP_MIN_CYC - 1))
				rt_run_q <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			o_rt_reply_go <= 1'b0;
		else
			o_rt_reply_go <= !i_rt_cmd_parity && rt_run_q &&
				rt_q == 10'(bmt_pkg::RESP_MIN_CYC - 1);
	end
endmodule

// ### bmt_pkg.sv
package bmt_pkg;
	localparam int CLK_MHZ = 125;
	localparam int NS_PER_CLK = 8;
	// Times in ns, as typical figures
	localparam int START_DLY_NS = 2500;
	localparam int GAP_MIN_NS = 9500;
	localparam int STEP_NS = 1000;
	localparam int RESP_MIN_NS = 4000;
	localparam int RESP_MAX_NS = 7000;
	localparam int TO_0_NS = 18500;
	localparam int TO_1_NS = 22500;
	localparam int TO_2_NS = 50500;
	localparam int TO_3_NS = 128000;
	// Cycle counts derived from the times, then fixed counts and the gap reset value
	localparam int START_DLY_CYC = START_DLY_NS / NS_PER_CLK;
	localparam int GAP_MIN_CYC = GAP_MIN_NS / NS_PER_CLK;
	localparam int STEP_CYC = STEP_NS / NS_PER_CLK;
	localparam int RESP_MIN_CYC = (RESP_MIN_NS + NS_PER_CLK - 1) / NS_PER_CLK;
	localparam int RESP_MAX_CYC = RESP_MAX_NS / NS_PER_CLK;
	localparam int HOST_EXT_CYC = 6;
	localparam int START_XFERS = 7;
	localparam int END_XFERS = 5;
	localparam int HOST_EXT_MAX_CYC = HOST_EXT_CYC * (START_XFERS + END_XFERS);
	localparam int SEQ_EXTRA_CYC = 10;
	localparam logic [15:0] GAP_RESET = 16'h0000;

	typedef enum logic [1:0] {
		BMT_TO_18P5,
		BMT_TO_22P5,
		BMT_TO_50P5,
		BMT_TO_128
	} bmt_timeout_t;

	typedef struct packed {
		logic seq_mode;
		logic host_prio;
		logic [15:0] gap_steps;
		bmt_timeout_t timeout_sel;
	} bmt_cfg_t;

	function automatic logic [15:0] bmt_timeout_cyc(input bmt_timeout_t sel);
		unique case (sel)
			BMT_TO_18P5: bmt_timeout_cyc = 16'(TO_0_NS / NS_PER_CLK);
			BMT_TO_22P5: bmt_timeout_cyc = 16'(TO_1_NS / NS_PER_CLK);
			BMT_TO_50P5: bmt_timeout_cyc = 16'(TO_2_NS / NS_PER_CLK);
			BMT_TO_128: bmt_timeout_cyc = 16'(TO_3_NS / NS_PER_CLK);
		endcase
	endfunction
endpackage

// ### bmt_rt_model.sv
`timescale 1ns/1ps
module bmt_rt_model (
	input wire logic i_mclk,
	input wire logic i_cmd,
	input wire logic [15:0] i_dly,
	output logic o_sync
);
	logic [15:0] cnt_q = 16'h0000;
	// Status sync i_dly cycles after command; zero stays silent
	always @(posedge i_mclk) cnt_q <= i_cmd ? i_dly : cnt_q - 16'(cnt_q != 16'h0000);
	assign o_sync = cnt_q == 16'h0001;
endmodule

// ### bmt_timing_monitor.sv
`timescale 1ns/1ps
module bmt_monitor (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_bc_start,
	input wire logic i_resp_arm,
	input wire logic i_rt_cmd_parity,
	input wire logic o_msg_go,
	input wire logic o_no_resp,
	input wire logic o_rt_reply_go,
	input wire bmt_pkg::bmt_cfg_t i_cfg
);
	localparam int TO_CYC [4] = '{2312, 2812, 6312, 16000};
	logic [15:0] wait_q, to_cyc;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	assign to_cyc = 16'(TO_CYC[i_cfg.timeout_sel]);
	// Cycles since the last timeout start
	always_ff @(posedge i_mclk) wait_q <= (i_sys_rst || i_resp_arm) ? 16'h0000 : wait_q + 16'h0001;
	first_msg_a: assert property (i_bc_start && !i_cfg.seq_mode |-> ##[313:315] o_msg_go)
		else $error("first message time");
	start_quiet_a: assert property (i_bc_start |=> !o_msg_go [*8]) else $error("early go");
	go_pulse_a: assert property (o_msg_go |=> !o_msg_go) else $error("go width");
	nr_time_a: assert property (o_no_resp |-> wait_q - to_cyc <= 16'h0002) else $error("timeout");
	nr_pulse_a: assert property (o_no_resp |=> !o_no_resp) else $error("nr width");
	rt_delay_a: assert property (i_rt_cmd_parity |-> ##[501:503] o_rt_reply_go) else $error("reply");
	rt_quiet_a: assert property (i_rt_cmd_parity |=> !o_rt_reply_go [*8]) else $error("early");
	rt_pulse_a: assert property (o_rt_reply_go |=> !o_rt_reply_go) else $error("rt width");
endmodule
bind bmt_timing bmt_monitor mon_u (.*);

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam int TO_CYC [4] = '{2312, 2812, 6312, 16000};
	logic clk = 1'b0, rst = 1'b1, st = 1'b0, dn = 1'b0, mo = 1'b1, arm = 1'b0, par = 1'b0, sync, go, nr, rg;
	logic xs = 1'b0, xe = 1'b0, ha = 1'b0;
	logic [15:0] dly = 16'h0000;
	bmt_pkg::bmt_cfg_t cfg = '0;
	int fail_count = 0, tests_run = 0, n;
	always #4 clk = ~clk;
	bmt_timing dut_u (.i_mclk(clk), .i_sys_rst(rst), .i_cfg(cfg), .i_bc_start(st), .i_msg_done(dn), .i_more_msgs(mo),
		.i_xfer_start_seq(xs), .i_xfer_end_seq(xe), .i_host_access(ha), .i_resp_arm(arm), .i_resp_sync(sync),
		.i_rt_cmd_parity(par), .o_msg_go(go), .o_no_resp(nr), .o_rt_reply_go(rg));
	bmt_rt_model rt_u (.i_mclk(clk), .i_cmd(arm), .i_dly(dly), .o_sync(sync));
	task automatic results;
		$display("Runs %0d fails %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	// Pulse one request, count cycles to its answer; quiet runs expect none
	task automatic fire(input int w, input int lim, input bit q);
		@(posedge clk);
		{st, dn, arm, par} <= 4'h8 >> w;
		@(posedge clk);
		{st, dn, arm, par} <= 4'h0;
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (n < lim && (w < 2 ? go : w == 2 ? nr : rg) !== 1'b1);
		if (n == lim && !q) fail_count++;
		if (n == lim && !q) results();
	endtask
	task automatic t_bc(input logic seq, input int steps);
		int lo, hi;
		lo = bmt_pkg::GAP_MIN_CYC + 10 * seq;
		hi = lo + steps * bmt_pkg::STEP_CYC + 4;
		if (steps * bmt_pkg::STEP_CYC > lo) lo = steps * bmt_pkg::STEP_CYC;
		@(posedge clk);
		cfg.seq_mode <= seq;
		cfg.gap_steps <= 16'(steps);
		mo <= 1'b1;
		fire(0, 1000, 0);
		if (!seq) chk(32'(n >= 312 && n <= 314), 1);
		fire(1, hi + 20, 0);
		chk(32'(n >= lo && n <= hi), 1);
		@(posedge clk);
		mo <= 1'b0;
		fire(1, hi + 20, 1);
		chk(n, hi + 20);
	endtask
	task automatic t_to;
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			cfg.timeout_sel <= bmt_pkg::bmt_timeout_t'(s);
			fire(2, TO_CYC[s] + 20, 0);
			chk(32'(n >= TO_CYC[s] && n <= TO_CYC[s] + 2), 1);
		end
		@(posedge clk);
		dly <= 16'h0064;
		fire(2, TO_CYC[3] + 20, 1);
		chk(n, TO_CYC[3] + 20);
	endtask
	task automatic t_rt;
		fire(3, 900, 0);
		chk(32'(n >= 500 && n <= 502), 1);
	endtask
	// With host_prio set, host accesses during a transfer sequence stretch the next gap
	task automatic t_host(input logic prio, input int acc, input logic eseq);
		int cap, ext;
		cap = bmt_pkg::START_XFERS + bmt_pkg::END_XFERS;
		ext = prio ? bmt_pkg::HOST_EXT_CYC * (acc < cap ? acc : cap) : 0;
		@(posedge clk);
		cfg.host_prio <= prio;
		cfg.seq_mode <= 1'b0;
		cfg.gap_steps <= 16'h0000;
		mo <= 1'b1;
		fire(0, 1000, 0);
		chk(n, bmt_pkg::START_DLY_CYC);
		@(posedge clk);
		{xs, xe, ha} <= {!eseq, eseq, 1'b1};
		repeat (acc) @(posedge clk);
		{xs, xe, ha} <= 3'h0;
		fire(1, 1500, 0);
		chk(n, bmt_pkg::GAP_MIN_CYC + ext);
		@(posedge clk);
		mo <= 1'b0;
		fire(1, 20, 1);
		chk(n, 20);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_bc(1'b0, 0);
		t_bc(1'b1, 20);
		t_bc(1'b1, 0);
		t_host(1'b0, 3, 1'b0);
		t_host(1'b1, 3, 1'b0);
		t_host(1'b1, 14, 1'b1);
		t_rt();
		t_to();
		results();
	end
endmodule
